// file: verilog/thcm_top.sv
/*
  Thermal clock modulator top: trip comparison with hysteresis,
  automatic and on-demand modulation, over-temperature indicator,
  catastrophic trip and software registers.
  Assumes a synchronous temperature code and a simple register port.
*/
// Chosen here: strobed register access and the address map.
`include "thcm_params.svh"
`default_nettype none

module thcm_top
  import thcm_pkg::*;
#(
  parameter int STEP = `THCM_STEP_CYCLES
)
(
  // Clock and reset
  input  wire logic        i_core_clk,
  input  wire logic        i_reset,
  // Register port
  input  wire logic [7:0]  i_addr,
  input  wire logic [31:0] i_wr_data,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output var  logic [31:0] o_rd_data,
  // Sensor and power state
  input  wire logic [7:0]  i_temp_code,
  input  wire logic        i_low_power,
  // Interrupts
  input  wire logic        i_irq_req,
  input  wire logic        i_irq_ack,
  output var  logic        o_core_irq,
  // Core and pins
  output var  logic        o_core_clk_en,
  output var  logic        o_snoop_en,
  output var  logic        o_over_temp_indicator_n,
  output var  logic        o_catastrophic_trip_n
);

  logic       auto_en_ff;
  logic       od_en_ff;
  logic [2:0] od_duty_ff;
  logic       hot_ff;
  logic       trip_ff;
  thcm_mode_t mode_ff;
  thcm_mode_t nxt_mode;
  logic [2:0] duty_sel;
  logic       mod_active;
  logic       mod_clk_en;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_core_clk or posedge i_reset)
  begin
    if (i_reset)
      auto_en_ff <= `THCM_AUTO_EN_RST;
    else if (i_wr && i_addr == `THCM_ADDR_AUTO_CTL)
      auto_en_ff <= i_wr_data[`THCM_AUTO_EN_BIT];
  end

  always_ff @(posedge i_core_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      od_en_ff   <= `THCM_OD_EN_RST;
      od_duty_ff <= `THCM_OD_DUTY_RST;
    end
    else if (i_wr && i_addr == `THCM_ADDR_OD_CTL)
    begin
      od_en_ff   <= i_wr_data[`THCM_OD_EN_BIT];
      od_duty_ff <= i_wr_data[`THCM_OD_DUTY_MSB:`THCM_OD_DUTY_LSB];
    end
  end

  // Threshold never appears in read data
  always_ff @(posedge i_core_clk or posedge i_reset)
  begin
    if (i_reset)
      o_rd_data <= '0;
    else if (i_rd)
    begin
      unique case (i_addr)
        `THCM_ADDR_AUTO_CTL: o_rd_data <= 32'(auto_en_ff);
        `THCM_ADDR_OD_CTL:   o_rd_data <= {27'h0, od_en_ff, od_duty_ff, 1'b0};
        `THCM_ADDR_STATUS:   o_rd_data <= {27'h0, o_core_clk_en, trip_ff,
                                           !o_over_temp_indicator_n, hot_ff,
                                           mode_ff != THCM_IDLE};
        default:             o_rd_data <= '0;
      endcase
    end
    else
      o_rd_data <= '0;
  end

  // ----------------------------------------------------------------
  // Temperature comparison
  // ----------------------------------------------------------------
  always_ff @(posedge i_core_clk or posedge i_reset)
  begin
    if (i_reset)
      hot_ff <= 1'b0;
    else if (i_temp_code >= `THCM_TEMP_TRIP)
      hot_ff <= 1'b1;
    else if (i_temp_code < `THCM_TEMP_TRIP - `THCM_TEMP_HYST)
      hot_ff <= 1'b0;
  end

  always_ff @(posedge i_core_clk or posedge i_reset)
  begin
    if (i_reset)
      trip_ff <= 1'b0;
    else if (i_temp_code >= `THCM_TEMP_CAT)
      trip_ff <= 1'b1;
  end

  // ----------------------------------------------------------------
  // Mode selection
  // ----------------------------------------------------------------
  always_comb
  begin
    if (trip_ff)
      nxt_mode = THCM_TRIPPED;
    else if (auto_en_ff && hot_ff)
      nxt_mode = THCM_AUTO;
    else if (od_en_ff)
      nxt_mode = THCM_ONDEMAND;
    else
      nxt_mode = THCM_IDLE;
  end

  always_ff @(posedge i_core_clk or posedge i_reset)
  begin
    if (i_reset)
      mode_ff <= THCM_IDLE;
    else
      mode_ff <= nxt_mode;
  end

  always_comb
  begin
    mod_active = 1'b1;
    duty_sel   = `THCM_DUTY_HALF;
    unique case (mode_ff)
      THCM_IDLE:     mod_active = 1'b0;
      THCM_AUTO:     duty_sel   = `THCM_DUTY_HALF;
      THCM_ONDEMAND: duty_sel   = (od_duty_ff == 3'h0) ? `THCM_DUTY_HALF : od_duty_ff;
      THCM_TRIPPED:  mod_active = 1'b0;
    endcase
  end

  thcm_mod_gen #(
    .STEP (STEP)
  ) u_mod_gen (
    .i_core_clk (i_core_clk),
    .i_reset    (i_reset),
    .i_active   (mod_active),
    .i_duty     (duty_sel),
    .o_clk_en   (mod_clk_en)
  );

  thcm_irq_latch u_irq_latch (
    .i_core_clk (i_core_clk),
    .i_reset    (i_reset),
    .i_irq_req  (i_irq_req),
    .i_irq_ack  (i_irq_ack),
    .i_clk_on   (o_core_clk_en),
    .o_core_irq (o_core_irq)
  );

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  always_ff @(posedge i_core_clk or posedge i_reset)
  begin
    if (i_reset)
      o_core_clk_en <= 1'b1;
    else
      o_core_clk_en <= mod_clk_en && !trip_ff;
  end

  always_ff @(posedge i_core_clk or posedge i_reset)
  begin
    if (i_reset)
      o_snoop_en <= 1'b1;
    else
      o_snoop_en <= !trip_ff;
  end

  // Indicator frozen while in low power
  always_ff @(posedge i_core_clk or posedge i_reset)
  begin
    if (i_reset)
      o_over_temp_indicator_n <= 1'b1;
    else if (!i_low_power)
      o_over_temp_indicator_n <= !hot_ff;
  end

  // Driven straight from the sticky trip flag, no bus activity
  always_ff @(posedge i_core_clk or posedge i_reset)
  begin
    if (i_reset)
      o_catastrophic_trip_n <= 1'b1;
    else
      o_catastrophic_trip_n <= !trip_ff;
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_trip_sticky: assert property (
    @(posedge i_core_clk) disable iff (i_reset)
    !o_catastrophic_trip_n |=> !o_catastrophic_trip_n)
    else $error("catastrophic trip released");

  a_trip_raise: assert property (
    @(posedge i_core_clk) disable iff (i_reset)
    i_temp_code >= `THCM_TEMP_CAT |=> ##1 (!o_catastrophic_trip_n && !o_core_clk_en))
    else $error("trip not raised two cycles after overheat");

  a_auto_over: assert property (
    @(posedge i_core_clk) disable iff (i_reset)
    (auto_en_ff && hot_ff && !trip_ff) |=> (mode_ff == THCM_AUTO && duty_sel == `THCM_DUTY_HALF))
    else $error("automatic mode did not take precedence");

  a_od_start: assert property (
    @(posedge i_core_clk) disable iff (i_reset)
    (i_wr && i_addr == `THCM_ADDR_OD_CTL && i_wr_data[`THCM_OD_EN_BIT] && !trip_ff
     && i_temp_code < `THCM_TEMP_CAT) |=> ##1 mod_active)
    else $error("on-demand write did not start modulation");

  a_hyst_hold: assert property (
    @(posedge i_core_clk) disable iff (i_reset)
    (hot_ff && i_temp_code >= `THCM_TEMP_TRIP - `THCM_TEMP_HYST) |=> hot_ff)
    else $error("trip released inside hysteresis band");

  a_lp_no_new: assert property (
    @(posedge i_core_clk) disable iff (i_reset)
    (i_low_power && o_over_temp_indicator_n) |=> o_over_temp_indicator_n)
    else $error("indicator newly asserted in low power");

  a_lp_hold: assert property (
    @(posedge i_core_clk) disable iff (i_reset)
    (i_low_power && !o_over_temp_indicator_n) |=> !o_over_temp_indicator_n)
    else $error("indicator released in low power");

  a_cool_idle: assert property (
    @(posedge i_core_clk) disable iff (i_reset)
    (!od_en_ff && !hot_ff && !trip_ff) |=> ##2 (o_core_clk_en || !o_catastrophic_trip_n))
    else $error("modulation continued after cooling");

  a_snoop_trip: assert property (
    @(posedge i_core_clk) disable iff (i_reset)
    trip_ff |=> !o_snoop_en)
    else $error("snoop still enabled after catastrophic trip");

  a_trip_clk_off: assert property (
    @(posedge i_core_clk) disable iff (i_reset)
    trip_ff |=> !o_core_clk_en)
    else $error("core clock running after catastrophic trip");

  a_trip_mode: assert property (
    @(posedge i_core_clk) disable iff (i_reset)
    trip_ff |=> mode_ff == THCM_TRIPPED)
    else $error("mode left tripped state without reset");

  a_rd_idle: assert property (
    @(posedge i_core_clk) disable iff (i_reset)
    !i_rd |=> o_rd_data == 32'h0)
    else $error("read data driven without a read");

  a_ind_follow: assert property (
    @(posedge i_core_clk) disable iff (i_reset)
    !i_low_power |=> o_over_temp_indicator_n == !$past(hot_ff))
    else $error("indicator does not follow the hot flag");

  a_hot_set: assert property (
    @(posedge i_core_clk) disable iff (i_reset)
    i_temp_code >= `THCM_TEMP_TRIP |=> hot_ff)
    else $error("hot flag not set at trip temperature");

  a_cold_clear: assert property (
    @(posedge i_core_clk) disable iff (i_reset)
    i_temp_code < (`THCM_TEMP_TRIP - `THCM_TEMP_HYST) |=> !hot_ff)
    else $error("hot flag not cleared below release level");

endmodule

`default_nettype wire

// file: verilog/thcm_params.svh
/*
  Constants of the thermal clock modulator: register offsets, field
  positions, reset values, fixed temperature thresholds and timing.
  Assumes temperature codes are unsigned degrees Celsius.
*/
`ifndef THCM_PARAMS_SVH
`define THCM_PARAMS_SVH

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define THCM_ADDR_AUTO_CTL  8'h00
`define THCM_ADDR_OD_CTL    8'h04
`define THCM_ADDR_STATUS    8'h08

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define THCM_AUTO_EN_BIT    0
`define THCM_OD_EN_BIT      4
`define THCM_OD_DUTY_MSB    3
`define THCM_OD_DUTY_LSB    1
`define THCM_AUTO_EN_RST    1'b0
`define THCM_OD_EN_RST      1'b0
`define THCM_OD_DUTY_RST    3'h4

// ----------------------------------------------------------------
// Fixed thresholds and modulation
// ----------------------------------------------------------------
`define THCM_TEMP_TRIP      8'h64
`define THCM_TEMP_HYST      8'h02
`define THCM_TEMP_CAT       8'h7d
`define THCM_DUTY_HALF      3'h4
`define THCM_STEP_CYCLES    4

`endif

// file: verilog/thcm_pkg.sv
/*
  Types of the thermal clock modulator.
  Assumes nothing of its surroundings.
*/
`default_nettype none

package thcm_pkg;

  // ----------------------------------------------------------------
  // Operating mode of the thermal control circuit
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    THCM_IDLE,
    THCM_AUTO,
    THCM_ONDEMAND,
    THCM_TRIPPED
  } thcm_mode_t;

endpackage

`default_nettype wire

// file: verilog/thcm_mod_gen.sv
/*
  Clock modulation generator: free-running period counter and duty
  compare producing the core clock enable.
  Assumes active and duty are steady registered controls.
*/
`include "thcm_params.svh"
`default_nettype none

module thcm_mod_gen
  import thcm_pkg::*;
#(
  parameter int STEP = `THCM_STEP_CYCLES
)
(
  // Clock and reset
  input  wire logic       i_core_clk,
  input  wire logic       i_reset,
  // Control
  input  wire logic       i_active,
  input  wire logic [2:0] i_duty,
  // Clock enable
  output var  logic       o_clk_en
);

  localparam int CW = $clog2(8 * STEP);

  logic [CW-1:0] cnt_ff;
  logic [CW-1:0] nxt_cnt;
  logic          nxt_clk_en;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [CW:0] on_limit(input logic [2:0] duty);
    on_limit = (CW+1)'(duty * STEP);
  endfunction

  // ----------------------------------------------------------------
  // Period counter
  // ----------------------------------------------------------------
  always_comb
  begin
    if (cnt_ff == CW'(8 * STEP - 1))
      nxt_cnt = '0;
    else
      nxt_cnt = cnt_ff + CW'(1);
  end

  always_ff @(posedge i_core_clk or posedge i_reset)
  begin
    if (i_reset)
      cnt_ff <= '0;
    else
      cnt_ff <= nxt_cnt;
  end

  // ----------------------------------------------------------------
  // Clock enable
  // ----------------------------------------------------------------
  always_comb
  begin
    nxt_clk_en = !i_active || ({1'b0, cnt_ff} < on_limit(i_duty));
  end

  always_ff @(posedge i_core_clk or posedge i_reset)
  begin
    if (i_reset)
      o_clk_en <= 1'b1;
    else
      o_clk_en <= nxt_clk_en;
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_idle_runs: assert property (
    @(posedge i_core_clk) disable iff (i_reset)
    !i_active |=> o_clk_en)
    else $error("clock gated while modulation inactive");

  a_period_start: assert property (
    @(posedge i_core_clk) disable iff (i_reset)
    (i_active && cnt_ff == '0 && i_duty != 3'h0) |=> o_clk_en)
    else $error("clock not on at period start");

  a_period_end: assert property (
    @(posedge i_core_clk) disable iff (i_reset)
    (i_active && cnt_ff == CW'(8 * STEP - 1) && i_duty != 3'h0) |=> !o_clk_en)
    else $error("clock not off at period end");

endmodule

`default_nettype wire

// file: verilog/thcm_irq_latch.sv
/*
  Interrupt latch: holds incoming interrupt requests while the core
  clock is gated and presents them only while it runs.
  Assumes the core acknowledges with a one-cycle pulse.
*/
`default_nettype none

module thcm_irq_latch
  import thcm_pkg::*;
(
  // Clock and reset
  input  wire logic i_core_clk,
  input  wire logic i_reset,
  // Request side
  input  wire logic i_irq_req,
  input  wire logic i_irq_ack,
  input  wire logic i_clk_on,
  // Core side
  output var  logic o_core_irq
);

  logic pend_ff;

  // ----------------------------------------------------------------
  // Latch; a new request wins over the acknowledge
  // ----------------------------------------------------------------
  always_ff @(posedge i_core_clk or posedge i_reset)
  begin
    if (i_reset)
      pend_ff <= 1'b0;
    else if (i_irq_req)
      pend_ff <= 1'b1;
    else if (i_irq_ack)
      pend_ff <= 1'b0;
  end

  always_ff @(posedge i_core_clk or posedge i_reset)
  begin
    if (i_reset)
      o_core_irq <= 1'b0;
    else
      o_core_irq <= pend_ff && i_clk_on && !i_irq_ack;
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_irq_held: assert property (
    @(posedge i_core_clk) disable iff (i_reset)
    (pend_ff && !i_irq_ack) |=> pend_ff)
    else $error("pending interrupt lost");

  a_irq_gated: assert property (
    @(posedge i_core_clk) disable iff (i_reset)
    !i_clk_on |=> !o_core_irq)
    else $error("interrupt presented while clock gated");

endmodule

`default_nettype wire

// file: testbench/thcm_platform_model.sv
/*
  Platform power and thermal logic model: removes core supply after a
  catastrophic trip and requests orderly shutdown when too hot while the over-temperature indicator is deasserted.
  Assumes the external temperature reading shares the sensor code.
*/
`default_nettype none

module thcm_platform_model
  import thcm_pkg::*;
#(
  parameter int         OFF_DELAY  = 4,
  parameter logic [7:0] SAFE_LIMIT = 8'h64
)
(
  // Clock and reset
  input  wire logic       i_core_clk,
  input  wire logic       i_reset,
  // Device pins
  input  wire logic       i_catastrophic_trip_n,
  input  wire logic       i_over_temp_indicator_n,
  input  wire logic [7:0] i_ext_temp,
  // Platform actions
  output var  logic       o_supply_off,
  output var  logic       o_shutdown_req
);
  timeunit 1ns;
  timeprecision 1ns;

  int unsigned trip_cnt_ff;

  // ----------------------------------------------------------------
  // Supply removal after trip
  // ----------------------------------------------------------------
  always_ff @(posedge i_core_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      trip_cnt_ff  <= 0;
      o_supply_off <= 1'b0;
    end
    else if (!i_catastrophic_trip_n)
    begin
      trip_cnt_ff <= trip_cnt_ff + 1;
      if (trip_cnt_ff >= OFF_DELAY)
      begin
        o_supply_off <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Orderly shutdown from external reading
  // ----------------------------------------------------------------
  always_ff @(posedge i_core_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      o_shutdown_req <= 1'b0;
    end
    else
    begin
      o_shutdown_req <= i_over_temp_indicator_n && (i_ext_temp >= SAFE_LIMIT);
    end
  end
endmodule

`default_nettype wire

// file: testbench/test_thcm_top.sv
/*
  Testbench of the thermal clock modulator: register, then duty table,
  automatic mode, interrupt, low power and trip cases.
  Assumes STEP = 1, so one modulation period is 8 core clocks.
*/
`default_nettype none

module test_thcm_top
  import thcm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic        i_core_clk;
  logic        i_reset;
  logic [7:0]  i_addr;
  logic [31:0] i_wr_data;
  logic        i_wr;
  logic        i_rd;
  logic [31:0] o_rd_data;
  logic [7:0]  i_temp_code;
  logic        i_low_power;
  logic        i_irq_req;
  logic        i_irq_ack;
  logic        o_core_irq;
  logic        o_core_clk_en;
  logic        o_snoop_en;
  logic        o_over_temp_indicator_n;
  logic        o_catastrophic_trip_n;
  logic        supply_off;
  logic        shutdown_req;
  logic [31:0] v;
  int          fail_count;
  int          cmp_count;

  // Row: on-demand register value and expected clock-on cycles in 64
  logic [31:0] row_od [9] = '{32'h00, 32'h10, 32'h12, 32'h14, 32'h16,
                              32'h18, 32'h1a, 32'h1c, 32'h1e};
  logic [31:0] row_on [9] = '{32'h40, 32'h20, 32'h08, 32'h10, 32'h18,
                              32'h20, 32'h28, 32'h30, 32'h38};

  thcm_top #(.STEP(1)) u_thcm_top (
    .i_core_clk              (i_core_clk),
    .i_reset                 (i_reset),
    .i_addr                  (i_addr),
    .i_wr_data               (i_wr_data),
    .i_wr                    (i_wr),
    .i_rd                    (i_rd),
    .o_rd_data               (o_rd_data),
    .i_temp_code             (i_temp_code),
    .i_low_power             (i_low_power),
    .i_irq_req               (i_irq_req),
    .i_irq_ack               (i_irq_ack),
    .o_core_irq              (o_core_irq),
    .o_core_clk_en           (o_core_clk_en),
    .o_snoop_en              (o_snoop_en),
    .o_over_temp_indicator_n (o_over_temp_indicator_n),
    .o_catastrophic_trip_n   (o_catastrophic_trip_n)
  );

  thcm_platform_model u_thcm_platform_model (
    .i_core_clk              (i_core_clk),
    .i_reset                 (i_reset),
    .i_catastrophic_trip_n   (o_catastrophic_trip_n),
    .i_over_temp_indicator_n (o_over_temp_indicator_n),
    .i_ext_temp              (i_temp_code),
    .o_supply_off            (supply_off),
    .o_shutdown_req          (shutdown_req)
  );

  // ----------------------------------------------------------------
  // Clock and watchdog
  // ----------------------------------------------------------------
  initial
  begin
    i_core_clk = 1'b0;
    forever #50 i_core_clk = ~i_core_clk;
  end

  initial
  begin
    repeat (20000) @(posedge i_core_clk);
    fail_count++;
    finish_test();
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge i_core_clk);
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_core_clk);
    i_wr      <= 1'b1;
    i_addr    <= a;
    i_wr_data <= d;
    @(posedge i_core_clk);
    i_wr      <= 1'b0;
  endtask

  task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge i_core_clk);
    i_rd   <= 1'b1;
    i_addr <= a;
    @(posedge i_core_clk);
    i_rd   <= 1'b0;
    @(negedge i_core_clk);
    d = o_rd_data;
  endtask

  task automatic count_on(output logic [31:0] n);
    n = 32'h0;
    repeat (64)
    begin
      @(negedge i_core_clk);
      n = n + {31'h0, o_core_clk_en};
    end
  endtask

  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    fail_count  = 0;
    cmp_count   = 0;
    i_reset     = 1'b1;
    i_addr      = 8'h00;
    i_wr_data   = 32'h0;
    i_wr        = 1'b0;
    i_rd        = 1'b0;
    i_temp_code = 8'h32;
    i_low_power = 1'b0;
    i_irq_req   = 1'b0;
    i_irq_ack   = 1'b0;
    settle(8);
    i_reset <= 1'b0;
    reg_rd(8'h00, v);
    check(v, 32'h0);
    reg_rd(8'h04, v);
    check(v, 32'h8);
    reg_rd(8'h08, v);
    check(v, 32'h10);
    reg_rd(8'h0c, v);
    check(v, 32'h0);
    for (int i = 0; i < 9; i++)
    begin
      reg_wr(8'h04, row_od[i]);
      reg_rd(8'h04, v);
      check(v, row_od[i]);
      settle(8);
      count_on(v);
      check(v, row_on[i]);
    end
    reg_wr(8'h04, 32'h0);
    reg_wr(8'h00, 32'h1);
    i_temp_code <= 8'h63;
    settle(4);
    check({31'h0, o_over_temp_indicator_n}, 32'h1);
    i_temp_code <= 8'h64;
    settle(4);
    check({31'h0, o_over_temp_indicator_n}, 32'h0);
    settle(8);
    count_on(v);
    check(v, 32'h20);
    check({31'h0, o_snoop_en}, 32'h1);
    reg_wr(8'h04, 32'h1e);
    settle(8);
    count_on(v);
    check(v, 32'h20);
    reg_wr(8'h04, 32'h0);
    i_temp_code <= 8'h62;
    settle(4);
    check({31'h0, o_over_temp_indicator_n}, 32'h0);
    i_temp_code <= 8'h61;
    settle(8);
    count_on(v);
    check(v, 32'h40);
    check({31'h0, o_over_temp_indicator_n}, 32'h1);
    reg_wr(8'h04, 32'h12);
    settle(8);
    i_irq_req <= 1'b1;
    settle(1);
    i_irq_req <= 1'b0;
    for (int k = 0; k < 32 && o_core_irq !== 1'b1; k++)
      settle(1);
    check({31'h0, o_core_irq}, 32'h1);
    i_irq_ack <= 1'b1;
    settle(1);
    i_irq_ack <= 1'b0;
    settle(16);
    check({31'h0, o_core_irq}, 32'h0);
    reg_wr(8'h04, 32'h0);
    i_low_power <= 1'b1;
    i_temp_code <= 8'h64;
    settle(4);
    check({31'h0, o_over_temp_indicator_n}, 32'h1);
    check({31'h0, shutdown_req}, 32'h1);
    i_temp_code <= 8'h32;
    settle(4);
    i_low_power <= 1'b0;
    i_temp_code <= 8'h64;
    settle(4);
    i_low_power <= 1'b1;
    i_temp_code <= 8'h32;
    settle(4);
    check({31'h0, o_over_temp_indicator_n}, 32'h0);
    i_low_power <= 1'b0;
    settle(4);
    check({31'h0, o_over_temp_indicator_n}, 32'h1);
    i_temp_code <= 8'h7d;
    settle(4);
    check({31'h0, o_catastrophic_trip_n}, 32'h0);
    check({31'h0, o_core_clk_en}, 32'h0);
    i_temp_code <= 8'h32;
    settle(10);
    check({31'h0, o_catastrophic_trip_n}, 32'h0);
    check({31'h0, supply_off}, 32'h1);
    check({31'h0, o_snoop_en}, 32'h0);
    reg_rd(8'h08, v);
    check(v, 32'h09);
    settle(1);
    i_reset <= 1'b1;
    settle(2);
    i_reset <= 1'b0;
    settle(2);
    check({31'h0, o_catastrophic_trip_n}, 32'h1);
    finish_test();
  end
endmodule

`default_nettype wire
